// File: verilog/iod_decoder.sv
// instruction operand decoder: splits fetched words into category and operand fields
// Overview of operation
// RULE1 - Instruction words are taken as 24-bit program memory words.
// RULE2 - Exactly three opcodes take two words and complete only after both are seen.
// RULE3 - A word splits into an 8-bit opcode and a 16-bit operand part.
// RULE4 - Every instruction lands in one of five categories.
// RULE5 - Register word ops yield base, second source and result registers with modifiers.
// RULE6 - File word ops yield a file address and a file-or-working-register-zero destination.
// RULE7 - Bit ops yield a register or file target and a literal or register bit position.
// RULE8 - Literal moves yield a literal and a register or file target.
// RULE9 - Literal arithmetic yields base register, literal, and a result only if different.
// RULE10 - MAC ops yield accumulator, multiplicands, X and Y prefetches and write-back.
// RULE11 - Other DSP ops yield accumulator, operand with modifier and a shift source.
// RULE12 - Control ops yield a program address and a table mode field.
// RULE13 - The first word of a two-word op is held until the second arrives.
`timescale 1ns/1ps
module iod_decoder
    import iod_pkg::*;
#(
    parameter int WORD_W = IOD_WORD_W
) (
    input wire logic clk_sys, // core clock
    input wire logic rst_n, // async reset, active low
    input wire logic fetch_valid, // fetched word present
    input wire logic [WORD_W-1:0] fetch_word, // fetched program word
    output logic dec_valid, // decoded instruction pulse
    output iod_cat_t dec_cat, // category
    output logic [IOD_OPC_W-1:0] dec_opcode, // opcode field
    output logic dec_two_word, // came from two words
    output logic dec_byte, // byte-wide operation
    output logic [IOD_REG_W-1:0] base_source_register, // first source
    output logic [IOD_REG_W-1:0] second_source_register, // second source
    output logic [IOD_AMD_W-1:0] src_mode, // source address modifier
    output logic [IOD_REG_W-1:0] result_register, // destination
    output logic [IOD_AMD_W-1:0] dst_mode, // destination address modifier
    output logic dst_valid, // separate destination decoded
    output logic [IOD_FILE_W-1:0] file_addr, // file register address
    output logic file_target, // target is file register
    output logic to_working_register_zero, // result goes to default_working_register
    output logic [IOD_BITPOS_W-1:0] bit_pos, // literal bit position
    output logic bit_pos_indirect, // bit position from base register
    output logic [IOD_LIT_W-1:0] literal, // literal value
    output logic acc_sel, // accumulator a=0 b=1
    output logic [IOD_MUL_W-1:0] mul_sel, // multiplicand register pair
    output logic [IOD_PF_W-1:0] pf_x, // x prefetch op and destination
    output logic [IOD_PF_W-1:0] pf_y, // y prefetch op and destination
    output logic acc_wb, // accumulator write-back
    output logic [IOD_REG_W-1:0] shift_count_register, // shift register
    output logic shift_by_reg, // shift from register, else literal
    output logic [IOD_ADDR_W-1:0] prog_addr, // program memory address
    output logic [IOD_TBL_W-1:0] tbl_mode // table access mode
);
    iod_state_t state_q;
    logic [WORD_W-1:0] first_q;
    logic is_two, done;
    logic [WORD_W-1:0] w;
    logic [IOD_LIT_W-1:0] ops;
    logic [IOD_OPC_W-1:0] opc;
    iod_cat_t cat;
    logic [IOD_GRP_W-1:0] grp;

    // two-word opcode lookup, applied to the fetch word only
    function automatic logic two_word_op(input logic [IOD_OPC_W-1:0] op);
        return (op == IOD_OP_GOTO) || (op == IOD_OP_CALL) || (op == IOD_OP_DO);
    endfunction

    // opcode group is the upper nibble; several decodes below share it
    function automatic logic [IOD_GRP_W-1:0] grp_of(input logic [IOD_OPC_W-1:0] op);
        return op[IOD_OPC_W-1 -: IOD_GRP_W];
    endfunction

    // category from the opcode's upper nibble
    function automatic iod_cat_t cat_of(input logic [IOD_OPC_W-1:0] op);
        case (grp_of(op))
            IOD_GRP_CTRL: return IOD_CAT_CTRL;
            IOD_GRP_LIT, IOD_GRP_LITAL: return IOD_CAT_LIT;
            IOD_GRP_BIT: return IOD_CAT_BIT;
            IOD_GRP_MAC, IOD_GRP_DSP: return IOD_CAT_DSP;
            default: return IOD_CAT_WORD;
        endcase
    endfunction

    // the word being decoded is the held first word once the second arrives
    always_comb begin
        is_two = two_word_op(fetch_word[IOD_OPC_LSB +: IOD_OPC_W]); // [RULE2]
        w = (state_q == IOD_ST_SECOND) ? first_q : fetch_word; // [RULE13]
        opc = w[IOD_OPC_LSB +: IOD_OPC_W]; // [RULE3]
        ops = w[IOD_LIT_W-1:0]; // [RULE1] [RULE3]
        cat = cat_of(opc); // [RULE4]
        grp = grp_of(opc);
        done = fetch_valid && ((state_q == IOD_ST_SECOND) || !is_two);
    end

    // gather state: hold the first of two words
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= IOD_ST_FIRST;
            first_q <= '0;
        end else if (fetch_valid) begin
            case (state_q)
                IOD_ST_FIRST: begin
                    if (is_two) begin
                        state_q <= IOD_ST_SECOND; // [RULE2] [RULE13]
                        first_q <= fetch_word;
                    end
                end
                IOD_ST_SECOND: state_q <= IOD_ST_FIRST;
                default: state_q <= IOD_ST_FIRST;
            endcase
        end
    end

    // general outputs; fields update only on a completed instruction
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dec_valid <= 1'b0;
            dec_cat <= IOD_CAT_WORD;
            dec_opcode <= '0;
            dec_two_word <= 1'b0;
            dec_byte <= 1'b0;
        end else begin
            dec_valid <= done;
            if (done) begin
                dec_cat <= cat; // [RULE4]
                dec_opcode <= opc; // [RULE3]
                dec_two_word <= (state_q == IOD_ST_SECOND);
                dec_byte <= ops[IOD_BYTE_BIT];
            end
        end
    end

    // register and file operand fields
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            base_source_register <= '0;
            second_source_register <= '0;
            src_mode <= '0;
            result_register <= '0;
            dst_mode <= '0;
            dst_valid <= 1'b0;
            file_addr <= '0;
            file_target <= 1'b0;
            to_working_register_zero <= 1'b0;
        end else if (done) begin
            base_source_register <= ops[IOD_BASE_LSB +: IOD_REG_W]; // [RULE5]
            second_source_register <= ops[IOD_RS_LSB +: IOD_REG_W]; // [RULE5]
            src_mode <= ops[IOD_AMD_S_LSB +: IOD_AMD_W]; // [RULE5] [RULE11]
            result_register <= ops[IOD_RD_LSB +: IOD_REG_W]; // [RULE5]
            dst_mode <= ops[IOD_AMD_D_LSB +: IOD_AMD_W];
            file_addr <= ops[IOD_FILE_W-1:0]; // [RULE6] [RULE7] [RULE8]
            file_target <= 1'b0;
            to_working_register_zero <= 1'b0;
            dst_valid <= (cat == IOD_CAT_WORD);
            case (cat)
                IOD_CAT_WORD: begin
                    if (opc[IOD_OPC_FILE_BIT]) begin
                        file_target <= 1'b1; // [RULE6]
                        to_working_register_zero <= !ops[IOD_FDIR_BIT]; // [RULE6]
                        dst_valid <= 1'b0;
                    end
                end
                IOD_CAT_BIT: file_target <= opc[IOD_OPC_FILE_BIT]; // [RULE7]
                IOD_CAT_LIT: begin
                    if (grp == IOD_GRP_LIT) begin
                        file_target <= opc[0]; // [RULE8]
                        result_register <= ops[IOD_RS_LSB +: IOD_REG_W];
                    end else begin
                        // result decoded only when it differs from the base source
                        dst_valid <= ops[IOD_RD_LSB +: IOD_REG_W]
                            != ops[IOD_BASE_LSB +: IOD_REG_W]; // [RULE9]
                    end
                end
                default: ;
            endcase
        end
    end

    // bit, literal, dsp and control fields
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bit_pos <= '0;
            bit_pos_indirect <= 1'b0;
            literal <= '0;
            acc_sel <= 1'b0;
            mul_sel <= '0;
            pf_x <= '0;
            pf_y <= '0;
            acc_wb <= 1'b0;
            shift_count_register <= '0;
            shift_by_reg <= 1'b0;
            prog_addr <= '0;
            tbl_mode <= '0;
        end else if (done) begin
            bit_pos <= ops[IOD_BITPOS_LSB +: IOD_BITPOS_W]; // [RULE7]
            bit_pos_indirect <= opc[IOD_OPC_IND_BIT]; // [RULE7]
            // moves carry a wide literal, arithmetic a short one
            if (grp == IOD_GRP_LIT)
                literal <= {{(IOD_LIT_W-IOD_LIT10_W){1'b0}},
                    ops[IOD_LIT10_LSB +: IOD_LIT10_W]}; // [RULE8]
            else
                literal <= {{(IOD_LIT_W-IOD_LIT5_W){1'b0}},
                    ops[IOD_LIT5_LSB +: IOD_LIT5_W]}; // [RULE9] [RULE11]
            acc_sel <= ops[IOD_ACC_BIT]; // [RULE10] [RULE11]
            mul_sel <= ops[IOD_MUL_LSB +: IOD_MUL_W]; // [RULE10]
            pf_x <= ops[IOD_PFX_LSB +: IOD_PF_W]; // [RULE10]
            pf_y <= ops[IOD_PFY_LSB +: IOD_PF_W]; // [RULE10]
            acc_wb <= ops[IOD_WB_BIT] && (grp == IOD_GRP_MAC); // [RULE10]
            shift_count_register <= ops[IOD_RS_LSB +: IOD_REG_W]; // [RULE11]
            shift_by_reg <= ops[IOD_SHW_BIT]; // [RULE11]
            // two-word ops take the high address bits from the second word
            if (state_q == IOD_ST_SECOND)
                prog_addr <= {fetch_word[IOD_ADDR_W-IOD_LIT_W-1:0], ops}; // [RULE12] [RULE13]
            else
                prog_addr <= {{(IOD_ADDR_W-IOD_LIT_W){1'b0}}, ops}; // [RULE12]
            tbl_mode <= ops[IOD_TBL_LSB +: IOD_TBL_W]; // [RULE12]
        end
    end

    // a two-word opcode in the first slot gives no decode until its partner arrives
    a_two_word_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE13]
        (fetch_valid && state_q == IOD_ST_FIRST && is_two) |=> !dec_valid)
        else $error("two-word first word decoded alone");

    // the partner word always completes the pair on the next edge
    a_pair_complete: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
        (fetch_valid && state_q == IOD_ST_SECOND) |=> (dec_valid && dec_two_word))
        else $error("second word did not complete");

    // ordinary words decode in one cycle with no hold
    a_single_word: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE1]
        (fetch_valid && state_q == IOD_ST_FIRST && !is_two)
        |=> (dec_valid && !dec_two_word))
        else $error("single word not decoded in one cycle");

    // no completed word, no pulse: a stale bus must never look like a decode
    a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE1]
        !done |=> !dec_valid)
        else $error("decode pulse without a completed word");

    // the opcode reported is the one of the word being decoded
    a_opcode_field: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
        done |=> dec_opcode == $past(opc))
        else $error("opcode field mismatch");

    // fields hold between decodes so execution may read them late
    a_fields_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
        !done |=> ($stable(dec_opcode) && $stable(literal) && $stable(prog_addr)))
        else $error("decoded fields changed without a decode");

    // control group lands in the control category
    a_cat_ctrl: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE4]
        (done && grp == IOD_GRP_CTRL) |=> dec_cat == IOD_CAT_CTRL)
        else $error("control category wrong");

    // register word ops always carry a separate result register
    a_word_dest: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE5]
        (done && cat == IOD_CAT_WORD && !opc[IOD_OPC_FILE_BIT])
        |=> (dst_valid && !file_target))
        else $error("register op destination wrong");

    // file word ops name no result register, only file or working register zero
    a_file_dest: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE6]
        (done && cat == IOD_CAT_WORD && opc[IOD_OPC_FILE_BIT])
        |=> (file_target && !dst_valid))
        else $error("file op destination wrong");

    // bit ops follow the opcode's file-select bit for their target
    a_bit_target: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE7]
        (done && cat == IOD_CAT_BIT) |=> file_target == $past(opc[IOD_OPC_FILE_BIT]))
        else $error("bit op target wrong");

    // moves carry only the wide literal field, upper bits clear
    a_move_literal: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE8]
        (done && grp == IOD_GRP_LIT) |=> literal[IOD_LIT_W-1:IOD_LIT10_W] == '0)
        else $error("move literal has stray high bits");

    // arithmetic on the same register reports no separate result
    a_lit_dest: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE9]
        (done && grp == IOD_GRP_LITAL
            && ops[IOD_RD_LSB +: IOD_REG_W] == ops[IOD_BASE_LSB +: IOD_REG_W])
        |=> !dst_valid)
        else $error("same-register result decoded");

    // dsp ops take the accumulator from the operand part
    a_acc_select: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE10]
        (done && cat == IOD_CAT_DSP) |=> acc_sel == $past(ops[IOD_ACC_BIT]))
        else $error("accumulator select wrong");

    // only the multiplying group may write an accumulator back
    a_mac_writeback: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE10]
        (done && cat == IOD_CAT_DSP && grp != IOD_GRP_MAC) |=> !acc_wb)
        else $error("write-back outside multiply group");

    // other dsp ops pick the shift source from the operand part
    a_shift_source: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE11]
        (done && grp == IOD_GRP_DSP) |=> shift_by_reg == $past(ops[IOD_SHW_BIT]))
        else $error("shift source wrong");

    // single words reach only the low program addresses
    a_prog_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE12]
        (done && state_q == IOD_ST_FIRST) |=> prog_addr[IOD_ADDR_W-1:IOD_LIT_W] == '0)
        else $error("single word set high address bits");

    // a pair's decode always follows a quiet cycle while the first word is held
    a_valid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE13]
        (dec_valid && dec_two_word) |-> !$past(dec_valid))
        else $error("two-word decode not preceded by hold");
endmodule // iod_decoder

// File: verilog/iod_pkg.sv
// package of constants for the instruction operand decoder
package iod_pkg;
    localparam int IOD_WORD_W = 24;
    localparam int IOD_OPC_W = 8;
    localparam int IOD_OPC_LSB = 16;
    localparam int IOD_REG_W = 4;
    localparam int IOD_LIT_W = 16;
    localparam int IOD_ADDR_W = 23;
    // field positions inside the operand part of a word
    localparam int IOD_RD_LSB = 7;
    localparam int IOD_AMD_D_LSB = 11;
    localparam int IOD_BASE_LSB = 11;
    localparam int IOD_RS_LSB = 0;
    localparam int IOD_AMD_S_LSB = 4;
    localparam int IOD_AMD_W = 3;
    localparam int IOD_BYTE_BIT = 14;
    localparam int IOD_FDIR_BIT = 13;
    localparam int IOD_FILE_W = 13;
    localparam int IOD_BITPOS_LSB = 12;
    localparam int IOD_BITPOS_W = 4;
    localparam int IOD_LIT10_LSB = 4;
    localparam int IOD_LIT10_W = 10;
    localparam int IOD_LIT5_LSB = 0;
    localparam int IOD_LIT5_W = 5;
    localparam int IOD_ACC_BIT = 15;
    localparam int IOD_PFX_LSB = 0;
    localparam int IOD_PF_W = 4;
    localparam int IOD_PFY_LSB = 4;
    localparam int IOD_WB_BIT = 8;
    localparam int IOD_MUL_LSB = 9;
    localparam int IOD_MUL_W = 3;
    localparam int IOD_TBL_LSB = 14;
    localparam int IOD_TBL_W = 2;
    localparam int IOD_SHW_BIT = 6;
    localparam int IOD_GRP_W = 4;
    // opcode bits that pick a file target and an indirect bit position
    localparam int IOD_OPC_FILE_BIT = 0;
    localparam int IOD_OPC_IND_BIT = 1;
    // opcode category bounds (upper nibble of opcode)
    localparam logic [3:0] IOD_GRP_CTRL = 4'h0;
    localparam logic [3:0] IOD_GRP_LIT = 4'h2;
    localparam logic [3:0] IOD_GRP_LITAL = 4'h5;
    localparam logic [3:0] IOD_GRP_BIT = 4'ha;
    localparam logic [3:0] IOD_GRP_FILE = 4'he;
    localparam logic [3:0] IOD_GRP_MAC = 4'hc;
    localparam logic [3:0] IOD_GRP_DSP = 4'hd;
    // the three two-word opcodes
    localparam logic [7:0] IOD_OP_GOTO = 8'h04;
    localparam logic [7:0] IOD_OP_CALL = 8'h02;
    localparam logic [7:0] IOD_OP_DO = 8'h08;
    typedef enum logic [2:0] {
        IOD_CAT_WORD = 3'b000,
        IOD_CAT_BIT = 3'b001,
        IOD_CAT_LIT = 3'b010,
        IOD_CAT_DSP = 3'b011,
        IOD_CAT_CTRL = 3'b100
    } iod_cat_t;
    typedef enum logic [0:0] {
        IOD_ST_FIRST = 1'b0,
        IOD_ST_SECOND = 1'b1
    } iod_state_t;
endpackage

// File: test/iod_fetch_model.sv
// fetch-side model that hands program words to the decoder
`timescale 1ns/1ps
module iod_fetch_model
    import iod_pkg::*;
(
    input wire logic clk_sys, // core clock
    output logic fetch_valid, // word present
    output logic [IOD_WORD_W-1:0] fetch_word // program word
);
    logic [IOD_WORD_W-1:0] last_q;
    initial begin
        fetch_valid = 1'b0;
        fetch_word = 24'h000000;
        last_q = 24'h000000;
    end
    // one whole word per cycle, changed on the falling edge
    task automatic send(input logic [IOD_WORD_W-1:0] w);
        @(negedge clk_sys);
        fetch_valid = 1'b1;
        fetch_word = w;
        last_q = w;
    endtask
    // idle bus shows the inverse so a stale word never looks valid
    task automatic idle();
        @(negedge clk_sys);
        fetch_valid = 1'b0;
        fetch_word = ~last_q;
    endtask
endmodule // iod_fetch_model

// File: test/testbench.sv
// self-checking bench for the instruction operand decoder
`timescale 1ns/1ps
module testbench
    import iod_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic fetch_valid;
    logic [23:0] fetch_word;
    iod_cat_t dec_cat;
    logic dec_valid, dec_two_word, dec_byte, dst_valid, file_target, to_working_register_zero;
    logic bit_pos_indirect, acc_sel, acc_wb, shift_by_reg;
    logic [7:0] dec_opcode;
    logic [3:0] base_source_register, second_source_register, result_register, bit_pos;
    logic [3:0] pf_x, pf_y, shift_count_register;
    logic [2:0] src_mode, dst_mode, mul_sel;
    logic [12:0] file_addr;
    logic [15:0] literal;
    logic [22:0] prog_addr;
    logic [1:0] tbl_mode;
    int error_cnt = 0;
    int n_checks = 0;

    iod_fetch_model fetch_i (.clk_sys, .fetch_valid, .fetch_word);
    iod_decoder iod_decoder_i (.clk_sys, .rst_n, .fetch_valid, .fetch_word, .dec_valid,
        .dec_cat, .dec_opcode, .dec_two_word, .dec_byte, .base_source_register,
        .second_source_register, .src_mode, .result_register, .dst_mode, .dst_valid,
        .file_addr, .file_target, .to_working_register_zero, .bit_pos, .bit_pos_indirect,
        .literal, .acc_sel, .mul_sel, .pf_x, .pf_y, .acc_wb, .shift_count_register,
        .shift_by_reg, .prog_addr, .tbl_mode);

    // 200 MHz core clock
    always #2.5 clk_sys = ~clk_sys;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one word in, then look while the decoded pulse stands
    task automatic fire(input logic [23:0] w);
        fetch_i.send(w);
        fetch_i.idle();
    endtask
    task automatic t_lit();
        fire(24'h200123);
        chk(dec_valid, 1);
        chk(dec_cat, IOD_CAT_LIT);
        chk(literal, 16'h0012);
        chk(result_register, 3);
        chk(file_target, 1'h0);
        fetch_i.idle();
        chk(dec_valid, 0);
        chk(literal, 16'h0012);
        // back to back, no idle between words
        fetch_i.send(24'h2003f1);
        fetch_i.send(24'h200456);
        chk(literal, 16'h003f);
        fetch_i.idle();
        chk(dec_valid, 1);
        chk({literal, result_register}, 20'h00456);
        fire(24'h210123);
        chk({file_target, literal}, 17'h10012);
    endtask
    task automatic t_word();
        fire(24'h104a35);
        chk(dec_cat, IOD_CAT_WORD);
        chk(dec_opcode, 8'h10);
        chk({base_source_register, second_source_register, src_mode}, 11'h4ab);
        chk({result_register, dst_mode, dec_byte}, 8'h43);
        chk({file_target, dst_valid}, 2'h1);
        fire(24'h110abc);
        chk({file_addr, to_working_register_zero}, 14'h1579);
        chk({file_target, dst_valid}, 2'h2);
        fire(24'h112abc);
        chk({dec_cat, to_working_register_zero}, 4'h0);
    endtask
    task automatic t_bit();
        fire(24'ha25007);
        chk({dec_cat, bit_pos, bit_pos_indirect}, 8'h2b);
        fire(24'ha05007);
        chk(bit_pos_indirect, 0);
        fire(24'ha15007);
        chk({file_target, bit_pos_indirect}, 2'h2);
    endtask
    task automatic t_lital();
        fire(24'h501995);
        chk({dec_cat, base_source_register, literal}, 23'h230015);
        chk(dst_valid, 0);
        fire(24'h501a15);
        chk({dst_valid, result_register}, 5'h14);
    endtask
    task automatic t_dsp();
        fire(24'hc08b7a);
        chk(dec_cat, IOD_CAT_DSP);
        chk({acc_sel, mul_sel, pf_x, pf_y, acc_wb}, 13'h1b4f);
        fire(24'hd08043);
        chk({dec_cat, acc_sel, shift_by_reg, shift_count_register}, 9'h0f3);
    endtask
    // each two-word opcode, with a gap before the second word
    task automatic t_pair();
        logic [7:0] ops [3] = '{8'h02, 8'h04, 8'h08};
        foreach (ops[i]) begin
            fire({ops[i], 16'h1234});
            chk(dec_valid, 0);
            fetch_i.idle();
            fire(24'h000005);
            chk({dec_valid, dec_two_word, dec_opcode}, {2'b11, ops[i]});
            chk(prog_addr, 23'h051234);
            chk(dec_cat, IOD_CAT_CTRL);
        end
        fire(24'h0ac000);
        chk({dec_two_word, tbl_mode}, 3'h3);
    endtask

    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog well beyond the fifty or so cycles the tests need
    initial begin
        #20000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        chk({dec_valid, dec_cat, literal}, 0);
        t_lit();
        t_word();
        t_bit();
        t_lital();
        t_dsp();
        t_pair();
        print_verdict();
    end
endmodule // testbench
